//--- rtl/lc2pm_pkg.sv
// package: offsets, field layout, reset values and carriers for the link control two
// and power management capability register bank.
// assumes a single core clock and a plain address/strobe register port.
package lc2pm_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;

  // register offsets; the plain port addresses them directly, with no byte scaling
  localparam logic [ADDR_W-1:0] OFF_LINK_CAP2 = 8'h6c;
  localparam logic [ADDR_W-1:0] OFF_LINK_CTL2 = 8'h70;
  localparam logic [ADDR_W-1:0] OFF_LINK_STS2 = 8'h72;
  localparam logic [ADDR_W-1:0] OFF_SLOT_CAP2 = 8'h74;
  localparam logic [ADDR_W-1:0] OFF_SLOT_CTL2 = 8'h78;
  localparam logic [ADDR_W-1:0] OFF_SLOT_STS2 = 8'h7a;
  localparam logic [ADDR_W-1:0] OFF_PM_CAP = 8'hc0;

  // link_control_two field layout
  localparam int TSPD_LSB = 0;
  localparam int TSPD_W = 4;
  localparam int COMPL_BIT = 4;
  localparam int SPDDIS_BIT = 5;

  // power_mgmt_capability_header field layout
  localparam int CAPABILITY_IDENTIFIER_LSB = 0;
  localparam int NXT_LSB = 8;
  localparam int VER_LSB = 16;
  localparam int EVCLK_BIT = 19;
  localparam int SPINIT_BIT = 21;
  localparam int AUX_LSB = 22;
  localparam int AUX_W = 3;
  localparam int D1_BIT = 25;
  localparam int D2_BIT = 26;
  localparam int PMESUP_LSB = 27;
  localparam int PMESUP_W = 5;

  // constant and reset values
  localparam logic [7:0] CAP_ID_PM = 8'h01;
  localparam logic [7:0] NXT_UPSTREAM = 8'h00;
  localparam logic [7:0] NXT_DOWNSTREAM = 8'hd0;
  localparam logic [2:0] PM_VERSION = 3'h3;
  localparam logic [PMESUP_W-1:0] PMESUP_DFLT = 5'h19;
  localparam logic [TSPD_W-1:0] TSPD_RST = 4'h0;

  // speed codes of the target speed field
  localparam logic [TSPD_W-1:0] SPD_GEN1 = 4'h1;
  localparam logic [TSPD_W-1:0] SPD_GEN2 = 4'h2;
  localparam logic [TSPD_W-1:0] SPD_SUPPORTED = SPD_GEN1;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } reg_req_t;

  typedef struct packed {
    logic [TSPD_W-1:0] speed_cap;
    logic [TSPD_W-1:0] compliance_speed;
    logic enter_compliance;
    logic auto_speed_ok;
  } link_ctl_t;

  typedef struct packed {
    logic [PMESUP_W-1:0] event_states;
    logic cold_forward;
  } pm_behavior_t;

endpackage

//--- rtl/lc2pm_regs.sv
// register bank: link control two block and power management capability header.
// assumes strap levels (port role, legacy mode, write lock) arrive from pins and
// are synchronised here; hot_reset_req is a one-cycle pulse from core logic.
//
// Overview of operation
// - downstream port caps advertised training speed by the target speed field.
// - target speed code 1 is 2.5 Gbps, code 2 is 5 Gbps, others reserved.
// - target speed field also selects speed for forced compliance, both port roles.
// - compliance bit is sticky; set it, hot reset, link enters compliance.
// - speed-change disable blocks autonomous speed changes except downward corrections; here it drops auto_speed_ok for all of them.
// - in legacy 1.1 mode the three link fields read zero, writes ignored.
// - capability header low byte reads constant 0x1.
// - next pointer defaults 0x0 upstream, 0xD0 downstream.
// - version field reads constant 0x3.
// - event clock bit reads zero.
// - special initialisation bit defaults to zero.
// - auxiliary current field reads zero.
// - event support field defaults to 0b11001.
// - no event forwarding in the cold-off state.
// - writing event support changes only the advertised value, not behaviour.
`timescale 1ns/1ps
module lc2pm_regs
  import lc2pm_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire reg_req_t req,
  output logic [DATA_W-1:0] rd_data_q,
  input wire logic strap_upstream,
  input wire logic strap_legacy_mode,
  input wire logic strap_write_lock,
  input wire logic hot_reset_req,
  output link_ctl_t link_ctl_q,
  output pm_behavior_t pm_behavior_q
);

  // strap synchronisers: bit 0 role, bit 1 legacy mode, bit 2 lock
  logic [2:0] strap_meta_q;
  logic [2:0] strap_sync_q;
  logic is_upstream;
  logic legacy_mode;
  logic write_locked;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      strap_meta_q <= 3'h0;
      strap_sync_q <= 3'h0;
    end else begin
      strap_meta_q <= {strap_write_lock, strap_legacy_mode, strap_upstream};
      strap_sync_q <= strap_meta_q;
    end
  end

  assign is_upstream = strap_sync_q[0];
  assign legacy_mode = strap_sync_q[1];
  assign write_locked = strap_sync_q[2];

  logic wr_ctl;
  logic wr_pm;
  assign wr_ctl = req.wr && (req.addr == OFF_LINK_CTL2) && !legacy_mode;
  assign wr_pm = req.wr && (req.addr == OFF_PM_CAP) && !write_locked;

  // link_control_two storage; speed and disable are cleared by hot reset
  logic [TSPD_W-1:0] tspd_q;
  logic compl_q;
  logic spddis_q;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      tspd_q <= TSPD_RST;
      spddis_q <= 1'b0;
    end else if (wr_ctl) begin
      tspd_q <= req.wdata[TSPD_LSB +: TSPD_W];
      spddis_q <= req.wdata[SPDDIS_BIT];
    end else if (hot_reset_req) begin
      tspd_q <= TSPD_RST;
      spddis_q <= 1'b0;
    end
  end

  // sticky: only a write or the full reset clears it, a hot reset does not
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      compl_q <= 1'b0;
    end else if (wr_ctl) begin
      compl_q <= req.wdata[COMPL_BIT];
    end
  end

  // effective values: legacy mode forces the fields to zero
  logic [TSPD_W-1:0] tspd_eff;
  logic compl_eff;
  logic spddis_eff;
  assign tspd_eff = legacy_mode ? TSPD_RST : tspd_q;
  assign compl_eff = legacy_mode ? 1'b0 : compl_q;
  assign spddis_eff = legacy_mode ? 1'b0 : spddis_q;

  // power management header writable fields
  logic [7:0] nxt_q;
  logic nxt_written_q;
  logic spinit_q;
  logic [PMESUP_W-1:0] pmesup_q;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      nxt_q <= NXT_UPSTREAM;
      nxt_written_q <= 1'b0;
      spinit_q <= 1'b0;
      pmesup_q <= PMESUP_DFLT;
    end else if (wr_pm) begin
      nxt_q <= req.wdata[NXT_LSB +: 8];
      nxt_written_q <= 1'b1;
      spinit_q <= req.wdata[SPINIT_BIT];
      pmesup_q <= req.wdata[PMESUP_LSB +: PMESUP_W];
    end
  end

  // the pointer default follows the port role, which is only known after the straps
  // settle, so it is chosen at read time until software overwrites it
  logic [7:0] nxt_eff;
  assign nxt_eff = nxt_written_q ? nxt_q : (is_upstream ? NXT_UPSTREAM : NXT_DOWNSTREAM);

  // read path
  logic [DATA_W-1:0] rd_d;
  always_comb begin
    rd_d = '0;
    if (req.rd) begin
      case (req.addr)
        OFF_LINK_CTL2: begin
          rd_d[TSPD_LSB +: TSPD_W] = tspd_eff;
          rd_d[COMPL_BIT] = compl_eff;
          rd_d[SPDDIS_BIT] = spddis_eff;
        end
        OFF_PM_CAP: begin
          rd_d[CAPABILITY_IDENTIFIER_LSB +: 8] = CAP_ID_PM;
          rd_d[NXT_LSB +: 8] = nxt_eff;
          rd_d[VER_LSB +: 3] = PM_VERSION;
          rd_d[EVCLK_BIT] = 1'b0;
          rd_d[SPINIT_BIT] = spinit_q;
          rd_d[AUX_LSB +: AUX_W] = 3'h0;
          rd_d[D1_BIT] = 1'b0;
          rd_d[D2_BIT] = 1'b0;
          rd_d[PMESUP_LSB +: PMESUP_W] = pmesup_q;
        end
        default: begin
          rd_d = '0;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rd_data_q <= '0;
    end else begin
      rd_data_q <= rd_d;
    end
  end

  // training speed cap; reserved codes fall back to the only supported rate
  logic [TSPD_W-1:0] cap_d;
  always_comb begin
    if (is_upstream || legacy_mode) begin
      cap_d = SPD_SUPPORTED;
    end else if (tspd_eff == SPD_GEN1 || tspd_eff == SPD_GEN2) begin
      cap_d = tspd_eff;
    end else begin
      cap_d = SPD_SUPPORTED;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      link_ctl_q <= '0;
    end else begin
      link_ctl_q.speed_cap <= cap_d;
      link_ctl_q.auto_speed_ok <= !spddis_eff;
      if (hot_reset_req) begin
        // speed latched before the hot reset clears the field
        link_ctl_q.enter_compliance <= compl_eff;
        link_ctl_q.compliance_speed <= tspd_eff;
      end else if (!compl_eff) begin
        link_ctl_q.enter_compliance <= 1'b0;
      end
    end
  end

  // event behaviour ignores the advertised field by design
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      pm_behavior_q <= '0;
    end else begin
      pm_behavior_q.event_states <= PMESUP_DFLT;
      pm_behavior_q.cold_forward <= 1'b0;
    end
  end

  // checks
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);

  property p_capability_identifier;
    req.rd && req.addr == OFF_PM_CAP |=> rd_data_q[CAPABILITY_IDENTIFIER_LSB +: 8] == CAP_ID_PM;
  endproperty
  a_capability_identifier: assert property (p_capability_identifier) else $error("capability id wrong");

  property p_version_and_zeros;
    req.rd && req.addr == OFF_PM_CAP |=> rd_data_q[VER_LSB +: 3] == PM_VERSION
      && !rd_data_q[EVCLK_BIT] && rd_data_q[AUX_LSB +: AUX_W] == 3'h0;
  endproperty
  a_version_and_zeros: assert property (p_version_and_zeros)
    else $error("pm header constant fields wrong");

  property p_no_intermediate;
    req.rd && req.addr == OFF_PM_CAP |=> !rd_data_q[D1_BIT] && !rd_data_q[D2_BIT];
  endproperty
  a_no_intermediate: assert property (p_no_intermediate)
    else $error("intermediate state bits set");

  property p_next_default;
    req.rd && req.addr == OFF_PM_CAP && !nxt_written_q |=>
      rd_data_q[NXT_LSB +: 8] == ($past(is_upstream) ? NXT_UPSTREAM : NXT_DOWNSTREAM);
  endproperty
  a_next_default: assert property (p_next_default) else $error("next pointer default");

  property p_legacy_zero;
    legacy_mode && req.rd && req.addr == OFF_LINK_CTL2 |=> rd_data_q == '0;
  endproperty
  a_legacy_zero: assert property (p_legacy_zero) else $error("legacy link fields");

  property p_reserved_zero;
    req.rd && req.addr != OFF_LINK_CTL2 && req.addr != OFF_PM_CAP |=> rd_data_q == '0;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("reserved read nonzero");

  property p_cap_downstream;
    !is_upstream && !legacy_mode && (tspd_q == SPD_GEN1 || tspd_q == SPD_GEN2)
      |=> link_ctl_q.speed_cap == $past(tspd_q);
  endproperty
  a_cap_downstream: assert property (p_cap_downstream) else $error("speed cap");

  property p_speed_disable;
    spddis_q && !legacy_mode |=> !link_ctl_q.auto_speed_ok;
  endproperty
  a_speed_disable: assert property (p_speed_disable) else $error("autonomous change");

  property p_compliance;
    hot_reset_req && compl_q && !legacy_mode |=> link_ctl_q.enter_compliance
      && link_ctl_q.compliance_speed == $past(tspd_q);
  endproperty
  a_compliance: assert property (p_compliance) else $error("compliance entry");

  property p_sticky;
    hot_reset_req && !wr_ctl |=> compl_q == $past(compl_q);
  endproperty
  a_sticky: assert property (p_sticky) else $error("compliance bit lost");

  property p_event_fixed;
    wr_pm ##1 1'b1 |=> pm_behavior_q.event_states == PMESUP_DFLT
      && !pm_behavior_q.cold_forward;
  endproperty
  a_event_fixed: assert property (p_event_fixed) else $error("event behaviour moved");

  // link control checks; these watch stored state too, so a lost write shows at once
  property p_reserved_speed;
    !is_upstream && !legacy_mode && tspd_q != SPD_GEN1 && tspd_q != SPD_GEN2
      |=> link_ctl_q.speed_cap == SPD_SUPPORTED;
  endproperty
  a_reserved_speed: assert property (p_reserved_speed)
    else $error("reserved code");

  property p_upstream_cap;
    is_upstream |=> link_ctl_q.speed_cap == SPD_SUPPORTED;
  endproperty
  a_upstream_cap: assert property (p_upstream_cap)
    else $error("upstream cap");

  property p_ctl_write;
    wr_ctl |=> tspd_q == $past(req.wdata[TSPD_LSB +: TSPD_W]);
  endproperty
  a_ctl_write: assert property (p_ctl_write)
    else $error("speed write lost");

  property p_ctl_upper_zero;
    req.rd && req.addr == OFF_LINK_CTL2 |=> rd_data_q[DATA_W-1:SPDDIS_BIT+1] == '0;
  endproperty
  a_ctl_upper_zero: assert property (p_ctl_upper_zero)
    else $error("ctl reserved bits");

  property p_compliance_speed;
    hot_reset_req |=> link_ctl_q.compliance_speed == $past(tspd_eff);
  endproperty
  a_compliance_speed: assert property (p_compliance_speed)
    else $error("compliance rate");

  property p_compliance_hold;
    link_ctl_q.enter_compliance && compl_eff && !hot_reset_req
      |=> link_ctl_q.enter_compliance;
  endproperty
  a_compliance_hold: assert property (p_compliance_hold)
    else $error("compliance dropped");

  property p_compliance_drop;
    !compl_eff |=> !link_ctl_q.enter_compliance;
  endproperty
  a_compliance_drop: assert property (p_compliance_drop)
    else $error("compliance kept");

  property p_hot_clears;
    hot_reset_req && !wr_ctl |=> tspd_q == TSPD_RST && !spddis_q;
  endproperty
  a_hot_clears: assert property (p_hot_clears)
    else $error("hot reset clear");

  property p_legacy_outputs;
    legacy_mode |=> link_ctl_q.auto_speed_ok && !link_ctl_q.enter_compliance
      && link_ctl_q.speed_cap == SPD_SUPPORTED;
  endproperty
  a_legacy_outputs: assert property (p_legacy_outputs)
    else $error("legacy outputs");

  property p_legacy_no_write;
    legacy_mode && req.wr && req.addr == OFF_LINK_CTL2 && !hot_reset_req
      |=> tspd_q == $past(tspd_q) && compl_q == $past(compl_q)
      && spddis_q == $past(spddis_q);
  endproperty
  a_legacy_no_write: assert property (p_legacy_no_write)
    else $error("legacy write taken");

  property p_legacy_hot;
    legacy_mode && hot_reset_req |=> link_ctl_q.compliance_speed == TSPD_RST;
  endproperty
  a_legacy_hot: assert property (p_legacy_hot)
    else $error("legacy compliance rate");

  property p_speed_enable;
    !spddis_eff |=> link_ctl_q.auto_speed_ok;
  endproperty
  a_speed_enable: assert property (p_speed_enable)
    else $error("speed change blocked");

  // header and bus checks
  property p_read_idle;
    !req.rd |=> rd_data_q == '0;
  endproperty
  a_read_idle: assert property (p_read_idle)
    else $error("read data outside slot");

  property p_spinit_default;
    req.rd && req.addr == OFF_PM_CAP && !nxt_written_q
      |=> !rd_data_q[SPINIT_BIT];
  endproperty
  a_spinit_default: assert property (p_spinit_default)
    else $error("init flag default");

  property p_pmesup_default;
    req.rd && req.addr == OFF_PM_CAP && !nxt_written_q
      |=> rd_data_q[PMESUP_LSB +: PMESUP_W] == PMESUP_DFLT;
  endproperty
  a_pmesup_default: assert property (p_pmesup_default)
    else $error("event support default");

  property p_no_cold_forward;
    1'b1 |=> !pm_behavior_q.cold_forward;
  endproperty
  a_no_cold_forward: assert property (p_no_cold_forward)
    else $error("cold forwarding");

  property p_pm_locked;
    req.wr && req.addr == OFF_PM_CAP && write_locked
      |=> pmesup_q == $past(pmesup_q) && spinit_q == $past(spinit_q)
      && nxt_q == $past(nxt_q);
  endproperty
  a_pm_locked: assert property (p_pm_locked)
    else $error("locked header written");

  c_compliance: cover property (hot_reset_req && compl_q ##1 link_ctl_q.enter_compliance);
  c_pm_write: cover property (wr_pm ##1 req.rd && req.addr == OFF_PM_CAP);
  c_ctl_rw: cover property (wr_ctl ##1 req.rd && req.addr == OFF_LINK_CTL2);
  c_legacy_read: cover property (legacy_mode && req.rd && req.addr == OFF_LINK_CTL2);
  c_upstream_compliance: cover property (is_upstream && hot_reset_req && compl_q);

endmodule

//--- dv/tb_top.sv
// testbench for the link control two and power management header register bank.
// assumes the design's own assertions run alongside; straps are driven directly here.
`timescale 1ns/1ps
module tb_top;
  import lc2pm_pkg::*;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  reg_req_t req = '0;
  logic [DATA_W-1:0] rd_data_q;
  logic strap_upstream = 1'b0;
  logic strap_legacy_mode = 1'b0;
  logic strap_write_lock = 1'b0;
  logic hot_reset_req = 1'b0;
  link_ctl_t link_ctl_q;
  pm_behavior_t pm_behavior_q;
  int errors = 0;
  int compares = 0;
  logic [7:0] rsv_addr [6] = '{8'h6c, 8'h72, 8'h74, 8'h78, 8'h7a, 8'h10};

  lc2pm_regs lc2pm_regs_i (
    .clk_sys(clk_sys), .rst(rst), .req(req), .rd_data_q(rd_data_q),
    .strap_upstream(strap_upstream), .strap_legacy_mode(strap_legacy_mode),
    .strap_write_lock(strap_write_lock), .hot_reset_req(hot_reset_req),
    .link_ctl_q(link_ctl_q), .pm_behavior_q(pm_behavior_q)
  );

  initial begin
    forever #25 clk_sys = ~clk_sys;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask

  task automatic do_reset();
    rst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    // straps need two edges through the synchronisers
    tick(3);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    req.addr <= a;
    req.wdata <= d;
    req.wr <= 1'b1;
    @(posedge clk_sys) req.wr <= 1'b0;
  endtask

  task automatic hot_pulse();
    @(posedge clk_sys) hot_reset_req <= 1'b1;
    @(posedge clk_sys) hot_reset_req <= 1'b0;
    tick(1);
  endtask

  task automatic chk32(input string n, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic chkctl(input logic [9:0] e);
    compares++;
    if (link_ctl_q !== e) begin
      errors++;
      $display("MISMATCH link_ctl_q expected %h seen %h", e, link_ctl_q);
    end
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] v;
    @(posedge clk_sys);
    req.addr <= a;
    req.rd <= 1'b1;
    // read data stands only in the cycle after the strobe
    @(posedge clk_sys) req.rd <= 1'b0;
    #1 v = rd_data_q;
    chk32($sformatf("reg %h", a), e, v);
  endtask

  task automatic t_defaults();
    chkctl({SPD_GEN1, 4'h0, 1'b0, 1'b1});
    chk32("pm_behavior_q", 32'h32, 32'(pm_behavior_q));
    rdchk(8'hc0, 32'hc803d001);
    tick(1);
    chk32("rd_data_q idle", 32'h0, rd_data_q);
    rdchk(8'h70, 32'h0);
    for (int i = 0; i < 6; i++) begin
      wr(rsv_addr[i], 32'hffffffff);
      rdchk(rsv_addr[i], 32'h0);
    end
    $display("test defaults done");
  endtask

  task automatic t_link();
    wr(8'h70, 32'hffff);
    tick(2);
    rdchk(8'h70, 32'h3f);
    chkctl({SPD_GEN1, 4'h0, 1'b0, 1'b0});
    wr(8'h70, 32'h22);
    tick(2);
    chkctl({SPD_GEN2, 4'h0, 1'b0, 1'b0});
    wr(8'h70, 32'h11);
    hot_pulse();
    chkctl({SPD_GEN1, SPD_GEN1, 1'b1, 1'b1});
    rdchk(8'h70, 32'h10);
    wr(8'h70, 32'h0);
    tick(2);
    chkctl({SPD_GEN1, SPD_GEN1, 1'b0, 1'b1});
    $display("test link control done");
  endtask

  task automatic t_pm();
    wr(8'hc0, 32'hffffffff);
    tick(2);
    rdchk(8'hc0, 32'hf823ff01);
    chk32("pm_behavior_q", 32'h32, 32'(pm_behavior_q));
    @(posedge clk_sys) strap_write_lock <= 1'b1;
    tick(3);
    wr(8'hc0, 32'h0);
    tick(1);
    rdchk(8'hc0, 32'hf823ff01);
    @(posedge clk_sys) strap_write_lock <= 1'b0;
    $display("test power header done");
  endtask

  task automatic t_upstream();
    @(posedge clk_sys) strap_upstream <= 1'b1;
    do_reset();
    rdchk(8'hc0, 32'hc8030001);
    wr(8'h70, 32'h12);
    hot_pulse();
    chkctl({SPD_GEN1, SPD_GEN2, 1'b1, 1'b1});
    @(posedge clk_sys) strap_upstream <= 1'b0;
    $display("test upstream done");
  endtask

  task automatic t_legacy();
    @(posedge clk_sys) strap_legacy_mode <= 1'b1;
    do_reset();
    wr(8'h70, 32'h3f);
    tick(2);
    rdchk(8'h70, 32'h0);
    chkctl({SPD_GEN1, 4'h0, 1'b0, 1'b1});
    hot_pulse();
    chkctl({SPD_GEN1, 4'h0, 1'b0, 1'b1});
    @(posedge clk_sys) strap_legacy_mode <= 1'b0;
    do_reset();
    $display("test legacy done");
  endtask

  task automatic final_report();
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  initial begin
    do_reset();
    t_defaults();
    t_link();
    t_pm();
    t_upstream();
    t_legacy();
    final_report();
  end

  // the full sequence needs about a hundred cycles; allow about a thousand
  initial begin
    #50000;
    errors++;
    final_report();
  end
endmodule
